//--- bench/test_hw_loop_exit_and_raw_stall.sv
`timescale 1ns/1ps
module test_hw_loop_exit_and_raw_stall;
  logic clk_in, rst_n_in, exec_en_in, loop_start_in, ctrl_wr_in;
  logic [23:0] loop_first_pc_in, fetch_pc_in, next_pc, st_reg, end_reg;
  logic [15:0] loop_len_in, ctrl_wdata_in, dst_addr_in;
  logic [13:0] loop_count_in, cnt_reg;
  logic dst_valid_in, src_valid_in, reload, done, active, exit_bit;
  logic stall, fhold, dhold;
  hlr_pkg::hlr_am_e dst_mode_in, src_mode_in;
  logic [3:0] dst_reg_in, src_reg_in;
  logic [2:0] level;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // Per case: dst mode [7:6], src mode [5:4], mapped address [2],
  // same register [1], stall expected [0]
  localparam logic [7:0] HZ_TAB [12] = '{8'h02, 8'h13, 8'h23, 8'h42, 8'h52,
    8'h62, 8'h82, 8'h57, 8'h67, 8'h93, 8'hA3, 8'h10};
  hlr_loop_ctrl hlr_loop_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .exec_en_in(exec_en_in), .loop_start_in(loop_start_in),
    .loop_first_pc_in(loop_first_pc_in), .loop_len_in(loop_len_in),
    .loop_count_in(loop_count_in), .ctrl_wr_in(ctrl_wr_in),
    .ctrl_wdata_in(ctrl_wdata_in), .fetch_pc_in(fetch_pc_in),
    .dst_valid_in(dst_valid_in), .dst_mode_in(dst_mode_in),
    .dst_reg_in(dst_reg_in), .dst_addr_in(dst_addr_in),
    .src_valid_in(src_valid_in), .src_mode_in(src_mode_in),
    .src_reg_in(src_reg_in), .next_pc_out(next_pc), .pc_reload_out(reload),
    .loop_done_out(done), .loop_start_reg_out(st_reg),
    .loop_end_reg_out(end_reg), .loop_count_reg_out(cnt_reg),
    .loop_nest_level_out(level), .loop_active_flag_out(active),
    .early_exit_bit_out(exit_bit), .stall_out(stall),
    .fetch_hold_out(fhold), .daddr_hold_out(dhold));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task conclude;
    $display("comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  always @(posedge clk_in) begin
    cycles++;
    // Whole run needs about a hundred cycles
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task do_loop(input logic [23:0] first, input logic [15:0] len,
               input logic [13:0] cnt);
    @(posedge clk_in);
    loop_start_in <= 1'b1;
    loop_first_pc_in <= first;
    loop_len_in <= len;
    loop_count_in <= cnt;
    @(posedge clk_in);
    loop_start_in <= 1'b0;
    #1;
  endtask : do_loop
  task hit(input logic [23:0] addr, input logic en);
    @(posedge clk_in);
    fetch_pc_in <= addr;
    exec_en_in <= en;
    @(posedge clk_in);
    fetch_pc_in <= 24'h000F00;
    exec_en_in <= 1'b1;
    #1;
  endtask : hit
  task exit_wr(input logic [15:0] v);
    @(posedge clk_in);
    ctrl_wr_in <= 1'b1;
    ctrl_wdata_in <= v;
    @(posedge clk_in);
    ctrl_wr_in <= 1'b0;
    #1;
  endtask : exit_wr
  task hazard(input logic [7:0] e);
    @(posedge clk_in);
    {dst_valid_in, src_valid_in} <= 2'h3;
    dst_mode_in <= hlr_pkg::hlr_am_e'(e[7:6]);
    src_mode_in <= hlr_pkg::hlr_am_e'(e[5:4]);
    dst_addr_in <= e[2] ? 16'h0004 : 16'h0800;
    dst_reg_in <= 4'h2;
    src_reg_in <= e[1] ? 4'h2 : 4'h3;
    @(posedge clk_in);
    #1;
    chk(stall, e[0]);
    chk({fhold, dhold}, {2{e[0]}});
    @(posedge clk_in);
    {dst_valid_in, src_valid_in} <= 2'h0;
    #1;
    chk(stall, 1'b0);
  endtask : hazard
  initial begin
    {rst_n_in, exec_en_in, loop_start_in, ctrl_wr_in} = 4'h4;
    {loop_first_pc_in, loop_len_in, loop_count_in} = '0;
    {ctrl_wdata_in, dst_addr_in, dst_reg_in, src_reg_in} = '0;
    {dst_valid_in, src_valid_in} = 2'h0;
    dst_mode_in = hlr_pkg::HLR_AM_NONE;
    src_mode_in = hlr_pkg::HLR_AM_NONE;
    fetch_pc_in = 24'h000F00;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk({level, active, exit_bit, stall, reload}, 24'h0);
    do_loop(24'h000100, 16'h0004, 14'h0002);
    chk(end_reg, 24'h000108);
    chk({level, active}, 4'h3);
    hit(24'h000108, 1'b0);
    chk(reload, 1'b0);
    hit(24'h000108, 1'b1);
    chk({reload, next_pc}, {1'b1, 24'h000100});
    chk(cnt_reg, 14'h0001);
    @(posedge clk_in);
    #1;
    chk(reload, 1'b0);
    hit(24'h000108, 1'b1);
    chk({reload, cnt_reg}, {1'b1, 14'h0000});
    hit(24'h000108, 1'b1);
    chk({done, reload, level, active}, 6'h20);
    do_loop(24'h000200, 16'h0003, 14'h0005);
    exit_wr(16'h0000);
    hit(24'h000206, 1'b1);
    chk({reload, cnt_reg}, {1'b1, 14'h0004});
    exit_wr(16'h0800);
    chk(exit_bit, 1'b0);
    hit(24'h000206, 1'b1);
    chk({done, reload, active, cnt_reg}, {3'h4, 14'h0004});
    // Exit written in the very cycle the end address is pre-fetched
    do_loop(24'h000700, 16'h0002, 14'h0005);
    @(posedge clk_in);
    fetch_pc_in <= 24'h000704;
    ctrl_wr_in <= 1'b1;
    ctrl_wdata_in <= 16'h0800;
    @(posedge clk_in);
    fetch_pc_in <= 24'h000F00;
    ctrl_wr_in <= 1'b0;
    #1;
    chk({reload, cnt_reg}, {1'b1, 14'h0004});
    hit(24'h000704, 1'b1);
    chk({done, reload, active}, 3'h4);
    do_loop(24'h000300, 16'h0004, 14'h0001);
    do_loop(24'h000400, 16'hFFFD, 14'h0000);
    chk(end_reg, 24'h0003FA);
    chk({level, active, st_reg[15:0]}, {4'h5, 16'h0400});
    hit(24'h0003FA, 1'b1);
    chk({done, level, active}, 5'h13);
    chk({st_reg[11:0], end_reg[11:0]}, 24'h300308);
    chk(cnt_reg, 14'h0001);
    hit(24'h000308, 1'b1);
    hit(24'h000308, 1'b1);
    chk({done, active}, 2'h2);
    do_loop(24'h000600, 16'h0000, 14'h0001);
    hit(24'h000600, 1'b1);
    chk({reload, next_pc}, {1'b1, 24'h000600});
    hit(24'h000600, 1'b1);
    chk({done, active}, 2'h2);
    do_loop(24'h000800, 16'hFFFF, 14'h0001);
    chk(end_reg, 24'h0007FE);
    hit(24'h0007FE, 1'b1);
    chk({reload, next_pc}, {1'b1, 24'h000800});
    hit(24'h0007FE, 1'b1);
    chk({done, active, cnt_reg}, {2'h2, 14'h0000});
    do_loop(24'h000500, 16'hFFFE, 14'h0003);
    chk(end_reg, 24'h0004FC);
    hit(24'h0004FC, 1'b1);
    chk(cnt_reg, 14'h0002);
    @(posedge clk_in);
    fetch_pc_in <= 24'h0004FC;
    loop_start_in <= 1'b1;
    @(posedge clk_in);
    fetch_pc_in <= 24'h000F00;
    loop_start_in <= 1'b0;
    #1;
    chk({active, cnt_reg}, {1'b1, 14'h0003});
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk({level, active, cnt_reg}, 18'h0);
    for (int i = 0; i < 12; i++) hazard(HZ_TAB[i]);
    conclude();
  end
endmodule : test_hw_loop_exit_and_raw_stall

//--- shared/hlr_pkg.sv
package hlr_pkg;
  localparam int PC_W = 24;
  localparam int CNT_W = 14;
  localparam int WREG_N = 16;
  localparam int WSEL_W = 4;
  localparam int DADDR_W = 16;
  localparam int LEN_W = 16;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_ONE = 3'h1;
  localparam logic [2:0] LVL_TWO = 3'h2;
  localparam logic [PC_W-1:0] PC_RST = 24'h000000;
  localparam logic [PC_W-1:0] INSTR_STEP = 24'h000002;
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
  localparam int EXIT_BIT_POS = 11;
  localparam logic [DADDR_W-1:0] WREG_MAP_MASK = 16'hFFE0;
  localparam logic [DADDR_W-1:0] WREG_MAP_BASE = 16'h0000;
  // Addressing modes of one operand
  typedef enum logic [1:0] {
    HLR_AM_DIRECT = 2'h0,
    HLR_AM_INDIRECT = 2'h1,
    HLR_AM_IND_MOD = 2'h2,
    HLR_AM_NONE = 2'h3
  } hlr_am_e;
endpackage : hlr_pkg

//--- verilog/hlr_loop_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Interrupts anywhere in the loop leave start, end, count untouched.
// - Returning from interrupt resumes the loop with no software help.
// - Writing one to the exit bit ends the loop after this iteration.
// - Exit written in last two instructions still allows one more pass.
// - Exit bit reads zero; writing zero does nothing.
// - Loop acts only when the end address is pre-fetched while active.
// - End address is start plus twice the signed length, may lie below start.
// - Length minus two re-runs the loop instruction forever.
// - Length minus one repeats until the zero count borrows.
// - Length zero repeats first instruction until count underflows.
// - Address calculation and access each take one cycle.
// - No stall when the write leaves the register or no EA uses it.
// - Hazard checked every cycle except a stall cycle; exactly one stall cycle inserted.
// - End match with nonzero count and no pending exit decrements it and reloads start; zero count ends.
// - Active flag is the OR of the nesting level bits.
// - A stall completes the write, holds addressing, PC and fetch.
module hlr_loop_ctrl (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic exec_en_in,
  input wire logic loop_start_in,
  input wire logic [hlr_pkg::PC_W-1:0] loop_first_pc_in,
  input wire logic [hlr_pkg::LEN_W-1:0] loop_len_in,
  input wire logic [hlr_pkg::CNT_W-1:0] loop_count_in,
  input wire logic ctrl_wr_in,
  input wire logic [15:0] ctrl_wdata_in,
  input wire logic [hlr_pkg::PC_W-1:0] fetch_pc_in,
  input wire logic dst_valid_in,
  input wire hlr_pkg::hlr_am_e dst_mode_in,
  input wire logic [hlr_pkg::WSEL_W-1:0] dst_reg_in,
  input wire logic [hlr_pkg::DADDR_W-1:0] dst_addr_in,
  input wire logic src_valid_in,
  input wire hlr_pkg::hlr_am_e src_mode_in,
  input wire logic [hlr_pkg::WSEL_W-1:0] src_reg_in,
  output logic [hlr_pkg::PC_W-1:0] next_pc_out,
  output logic pc_reload_out,
  output logic loop_done_out,
  output logic [hlr_pkg::PC_W-1:0] loop_start_reg_out,
  output logic [hlr_pkg::PC_W-1:0] loop_end_reg_out,
  output logic [hlr_pkg::CNT_W-1:0] loop_count_reg_out,
  output logic [2:0] loop_nest_level_out,
  output logic loop_active_flag_out,
  output logic early_exit_bit_out,
  output logic stall_out,
  output logic fetch_hold_out,
  output logic daddr_hold_out
);
  logic [hlr_pkg::PC_W-1:0] start_ff, nxt_start;
  logic [hlr_pkg::PC_W-1:0] end_ff, nxt_end;
  logic [hlr_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [hlr_pkg::PC_W-1:0] sh_start_ff, nxt_sh_start;
  logic [hlr_pkg::PC_W-1:0] sh_end_ff, nxt_sh_end;
  logic [hlr_pkg::CNT_W-1:0] sh_cnt_ff, nxt_sh_cnt;
  logic [2:0] lvl_ff, nxt_lvl;
  logic exit_ff, nxt_exit;
  logic [hlr_pkg::PC_W-1:0] npc_ff, nxt_npc;
  logic reload_ff, nxt_reload;
  logic done_ff, nxt_done;
  logic stall_ff, nxt_stall;
  logic active_ff, nxt_active;
  logic hazard;
  logic active;
  logic end_hit;
  logic finish;
  logic [hlr_pkg::PC_W-1:0] len_ext;

  hlr_raw_check u_raw (
    .dst_valid_in(dst_valid_in),
    .dst_mode_in(dst_mode_in),
    .dst_reg_in(dst_reg_in),
    .dst_addr_in(dst_addr_in),
    .src_valid_in(src_valid_in),
    .src_mode_in(src_mode_in),
    .src_reg_in(src_reg_in),
    .hazard_out(hazard)
  );

  assign active = |lvl_ff;

  always_comb begin
    nxt_start = start_ff;
    nxt_end = end_ff;
    nxt_cnt = cnt_ff;
    nxt_sh_start = sh_start_ff;
    nxt_sh_end = sh_end_ff;
    nxt_sh_cnt = sh_cnt_ff;
    nxt_lvl = lvl_ff;
    nxt_exit = exit_ff;
    nxt_reload = 1'b0;
    nxt_done = 1'b0;
    nxt_npc = npc_ff;
    finish = 1'b0;
    // Word offset in instructions, sign-extended, two bytes per instruction
    len_ext = {{(hlr_pkg::PC_W-hlr_pkg::LEN_W){loop_len_in[hlr_pkg::LEN_W-1]}},
               loop_len_in} << 1;
    // Interrupt entry and return never reach these registers, so the state
    // simply persists across a handler
    end_hit = active && exec_en_in && (fetch_pc_in == end_ff);
    // Exit request is held until the end of the running iteration, so one
    // written late in the body still lets that pass complete
    if (ctrl_wr_in && ctrl_wdata_in[hlr_pkg::EXIT_BIT_POS] && active) begin
      nxt_exit = 1'b1;
    end
    if (end_hit) begin
      // Exit taken only at the end of the iteration in progress
      if (exit_ff || cnt_ff == hlr_pkg::CNT_ZERO) begin
        finish = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - hlr_pkg::CNT_ONE;
        nxt_reload = 1'b1;
        nxt_npc = start_ff;
      end
    end
    if (finish) begin
      // Zero count or a pending exit request ends the loop; fetch falls through
      nxt_exit = 1'b0;
      nxt_done = 1'b1;
      nxt_lvl = lvl_ff - hlr_pkg::LVL_ONE;
      if (lvl_ff == hlr_pkg::LVL_TWO) begin
        nxt_start = sh_start_ff;
        nxt_end = sh_end_ff;
        nxt_cnt = sh_cnt_ff;
      end
    end
    if (loop_start_in && exec_en_in) begin
      // Re-executing the loop instruction reloads the count every time,
      // which is why a length of minus two never ends
      if (active && !finish) begin
        nxt_sh_start = start_ff;
        nxt_sh_end = end_ff;
        nxt_sh_cnt = cnt_ff;
        nxt_lvl = (lvl_ff == hlr_pkg::LVL_TWO) ? lvl_ff :
                  lvl_ff + hlr_pkg::LVL_ONE;
      end else begin
        nxt_lvl = hlr_pkg::LVL_ONE;
      end
      nxt_start = loop_first_pc_in;
      nxt_end = loop_first_pc_in + len_ext;
      nxt_cnt = loop_count_in;
      nxt_exit = 1'b0;
    end
    // Registered copy so the flag leaves the block straight from a flop
    nxt_active = |nxt_lvl;
    // One stall cycle only; the stalled cycle itself is not rechecked
    nxt_stall = hazard && !stall_ff;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_ff <= hlr_pkg::PC_RST;
      end_ff <= hlr_pkg::PC_RST;
      cnt_ff <= hlr_pkg::CNT_ZERO;
      sh_start_ff <= hlr_pkg::PC_RST;
      sh_end_ff <= hlr_pkg::PC_RST;
      sh_cnt_ff <= hlr_pkg::CNT_ZERO;
      lvl_ff <= hlr_pkg::LVL_NONE;
      exit_ff <= 1'b0;
      npc_ff <= hlr_pkg::PC_RST;
      reload_ff <= 1'b0;
      done_ff <= 1'b0;
      stall_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
      end_ff <= nxt_end;
      cnt_ff <= nxt_cnt;
      sh_start_ff <= nxt_sh_start;
      sh_end_ff <= nxt_sh_end;
      sh_cnt_ff <= nxt_sh_cnt;
      lvl_ff <= nxt_lvl;
      exit_ff <= nxt_exit;
      npc_ff <= nxt_npc;
      reload_ff <= nxt_reload;
      done_ff <= nxt_done;
      stall_ff <= nxt_stall;
      active_ff <= nxt_active;
    end
  end

  assign next_pc_out = npc_ff;
  assign pc_reload_out = reload_ff;
  assign loop_done_out = done_ff;
  assign loop_start_reg_out = start_ff;
  assign loop_end_reg_out = end_ff;
  assign loop_count_reg_out = cnt_ff;
  assign loop_nest_level_out = lvl_ff;
  assign loop_active_flag_out = active_ff;
  assign early_exit_bit_out = 1'b0;
  assign stall_out = stall_ff;
  assign fetch_hold_out = stall_ff;
  assign daddr_hold_out = stall_ff;

  AST_ACTIVE_OR: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    loop_active_flag_out == (|loop_nest_level_out))
    else $error("active flag differs from level OR");
  AST_ONE_STALL: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    stall_ff |=> !stall_ff)
    else $error("stall lasted more than one cycle");
  AST_STALL_CAUSE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    hazard && !stall_ff |=> stall_ff)
    else $error("hazard without stall");
  AST_NO_SPURIOUS: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !hazard |=> !stall_ff)
    else $error("stall without hazard");
  AST_HOLDS: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    stall_out |-> fetch_hold_out && daddr_hold_out)
    else $error("stall without holds");
  AST_EXIT_RD0: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    early_exit_bit_out == 1'b0)
    else $error("exit bit read nonzero");
  AST_RELOAD: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    end_hit && !exit_ff && cnt_ff != hlr_pkg::CNT_ZERO && !loop_start_in
    |=> pc_reload_out && next_pc_out == $past(start_ff) &&
    loop_count_reg_out == $past(cnt_ff) - hlr_pkg::CNT_ONE)
    else $error("loop did not reload");
  AST_EXIT_END: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    end_hit && exit_ff && !loop_start_in |=> loop_done_out && !pc_reload_out)
    else $error("exit did not end loop");
  AST_END_ADDR: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    loop_start_in && exec_en_in |=> loop_end_reg_out ==
    $past(loop_first_pc_in) + $past(len_ext))
    else $error("end address wrong");
  AST_WRITE0: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !exit_ff && !(ctrl_wr_in && ctrl_wdata_in[hlr_pkg::EXIT_BIT_POS])
    |=> !exit_ff)
    else $error("exit set without a one");
endmodule : hlr_loop_ctrl

//--- verilog/hlr_raw_check.sv
`timescale 1ns/1ps
// Read-after-write check between the executing and the pre-fetched instr
module hlr_raw_check (
  input wire logic dst_valid_in,
  input wire hlr_pkg::hlr_am_e dst_mode_in,
  input wire logic [hlr_pkg::WSEL_W-1:0] dst_reg_in,
  input wire logic [hlr_pkg::DADDR_W-1:0] dst_addr_in,
  input wire logic src_valid_in,
  input wire hlr_pkg::hlr_am_e src_mode_in,
  input wire logic [hlr_pkg::WSEL_W-1:0] src_reg_in,
  output logic hazard_out
);
  logic dst_hits;
  logic src_uses_ea;
  logic [hlr_pkg::WSEL_W-1:0] mapped_reg;
  logic mapped_hit;

  always_comb begin
    // Working registers are word-mapped at the base of data space
    mapped_reg = dst_addr_in[hlr_pkg::WSEL_W:1];
    mapped_hit = ((dst_addr_in & hlr_pkg::WREG_MAP_MASK) ==
                  hlr_pkg::WREG_MAP_BASE) && (mapped_reg == src_reg_in);
    unique case (dst_mode_in)
      hlr_pkg::HLR_AM_DIRECT: dst_hits = (dst_reg_in == src_reg_in);
      hlr_pkg::HLR_AM_IND_MOD: dst_hits = (dst_reg_in == src_reg_in) ||
                                          mapped_hit;
      hlr_pkg::HLR_AM_INDIRECT: dst_hits = mapped_hit;
      hlr_pkg::HLR_AM_NONE: dst_hits = 1'b0;
    endcase
    src_uses_ea = (src_mode_in == hlr_pkg::HLR_AM_INDIRECT) ||
                  (src_mode_in == hlr_pkg::HLR_AM_IND_MOD);
    hazard_out = dst_valid_in && src_valid_in && dst_hits && src_uses_ea;
  end
endmodule : hlr_raw_check
